// file: rtl/pmps_pkg.sv
// Purpose: shared constants and types of the power-up sequencer
// Assumes: 25 MHz system clock, 32.768 kHz time base derived from it
// Notes:   times are in microseconds, counts are in time-base ticks
package pmps_pkg;

  // ==========================================================
  // clocking and timing
  localparam int unsigned CLK_HZ       = 32'h017D_7840;  // 25 MHz
  localparam int unsigned TB_HZ        = 32'h0000_8000;  // 32.768 kHz
  localparam int unsigned US_PER_S     = 32'h000F_4240;
  localparam int unsigned HALF_S_US    = 32'h0007_A120;
  localparam int unsigned PRESEQ_US    = 32'h0000_1F40;  // 8.0 ms
  localparam int unsigned SLOT_US      = 32'h0000_07D0;  // 2.0 ms
  localparam int unsigned PWM_HOLD_US  = 32'h0000_0BB8;  // 3.0 ms

  // nearest whole count, as the tick base is only nominal anyway
  localparam int unsigned TB_DIV_I     = (CLK_HZ + TB_HZ / 2) / TB_HZ;
  localparam int unsigned PRESEQ_I     = (PRESEQ_US * TB_HZ + HALF_S_US) / US_PER_S;
  localparam int unsigned SLOT_I       = (SLOT_US * TB_HZ + HALF_S_US) / US_PER_S;
  localparam int unsigned PWM_I        = (PWM_HOLD_US * TB_HZ + HALF_S_US) / US_PER_S;

  localparam logic [9:0]  TB_DIV       = 10'(TB_DIV_I);
  localparam logic [8:0]  PRESEQ_TICKS = 9'(PRESEQ_I);
  localparam logic [8:0]  SLOT_TICKS   = 9'(SLOT_I);
  localparam logic [6:0]  PWM_TICKS    = 7'(PWM_I);

  // ==========================================================
  // regulator enable vector layout (bucks occupy the low bits)
  localparam int NREG      = 13;
  localparam int NBUCK     = 5;
  localparam int EN_CORE   = 0;
  localparam int EN_VCC    = 1;
  localparam int EN_ANA    = 2;
  localparam int EN_MEM    = 3;
  localparam int EN_IO     = 4;
  localparam int EN_BOOST  = 5;
  localparam int EN_USB    = 6;
  localparam int EN_AUX    = 7;
  localparam int EN_GP1    = 8;
  localparam int EN_GP2    = 9;
  localparam int EN_PLL    = 10;
  localparam int EN_DAC    = 11;
  localparam int EN_MREF   = 12;

  // ==========================================================
  // slot tables, one enable mask per 2 ms slot
  localparam int          NSLOT     = 10;
  localparam logic [3:0]  LAST_SLOT = 4'h9;
  localparam logic [12:0] SLOT_A [NSLOT] = '{13'h0002, 13'h0400, 13'h0200, 13'h0004,
    13'h0001, 13'h1008, 13'h0000, 13'h0110, 13'h00C0, 13'h0800};
  localparam logic [12:0] SLOT_B [NSLOT] = '{13'h0002, 13'h0004, 13'h0001, 13'h0800,
    13'h1008, 13'h0010, 13'h0280, 13'h0400, 13'h0100, 13'h0040};

  // strap code ranges
  localparam logic [3:0]  CODE_A_LO = 4'h5;
  localparam logic [3:0]  CODE_A_HI = 4'h9;
  localparam logic [3:0]  CODE_B_LO = 4'hA;

  // ==========================================================
  // default output levels in millivolts
  localparam logic [11:0] MV_1100 = 12'h44C;
  localparam logic [11:0] MV_1200 = 12'h4B0;
  localparam logic [11:0] MV_1225 = 12'h4C9;
  localparam logic [11:0] MV_1300 = 12'h514;
  localparam logic [11:0] MV_1350 = 12'h546;
  localparam logic [11:0] MV_1500 = 12'h5DC;
  localparam logic [11:0] MV_1800 = 12'h708;
  localparam logic [11:0] MV_2500 = 12'h9C4;
  localparam logic [11:0] MV_2775 = 12'hAD7;
  localparam logic [11:0] MV_3100 = 12'hC1C;
  localparam logic [11:0] MV_3150 = 12'hC4E;
  localparam logic [11:0] MV_3300 = 12'hCE4;

  typedef struct packed {
    logic [11:0] core;
    logic [11:0] vcc;
    logic [11:0] ana;
    logic [11:0] mem_a;
    logic [11:0] mem_b;
    logic [11:0] io;
    logic [11:0] usb;
    logic [11:0] aux;
    logic [11:0] rtc;
    logic [11:0] pll;
    logic [11:0] dac;
    logic [11:0] gp1;
    logic [11:0] gp2;
  } pmps_levels_t;

  typedef enum logic [1:0] {MODE_OFF, MODE_PFM, MODE_APS, MODE_PWM} pmps_mode_t;
  typedef enum logic [1:0] {ST_OFF, ST_PRESEQ, ST_SLOTS, ST_DONE} pmps_state_t;

endpackage : pmps_pkg

// file: rtl/pmps_tick_gen.sv
// Purpose: one-cycle enable at the 32.768 kHz time-base rate
// Assumes: runs freely from reset release
// Notes:   divide ratio rounded to the nearest whole count
`timescale 1ns/1ps
module pmps_tick_gen
  import pmps_pkg::*;
#(
  // divide ratio, the 32.768 kHz time base unless a fast bench shortens it
  parameter logic [9:0] DIV = pmps_pkg::TB_DIV
)
(
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // time-base enable
  output logic      tick_out
);
  import pmps_pkg::*;

  // ==========================================================
  // divider
  logic [9:0] div_q;
  wire        wrap = (div_q == DIV - 10'h001);

  // free-running divider, wraps every DIV clocks
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 10'h000;
    end else begin
      div_q <= wrap ? 10'h000 : div_q + 10'h001;
    end
  end

  assign tick_out = wrap;

endmodule : pmps_tick_gen

// file: rtl/pmps_defaults_rom.sv
// Purpose: power-up default levels indexed by the latched strap code
// Assumes: code is stable for at least one clock before use
// Notes:   reserved codes read as all zero
`timescale 1ns/1ps
module pmps_defaults_rom
  import pmps_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  // lookup
  input  wire logic [3:0]            code_in,
  output pmps_pkg::pmps_levels_t     levels_out
);
  import pmps_pkg::*;

  // ==========================================================
  // table
  function automatic pmps_levels_t row(input logic [11:0] vcc, input logic [11:0] ana,
      input logic [11:0] mema, input logic [11:0] memb, input logic [11:0] rtc,
      input logic [11:0] dac, input logic [11:0] gp1, input logic [11:0] gp2);
    return '{core: MV_1100, vcc: vcc, ana: ana, mem_a: mema, mem_b: memb, io: MV_1800,
             usb: MV_3300, aux: MV_2500, rtc: rtc, pll: MV_1800, dac: dac, gp1: gp1,
             gp2: gp2};
  endfunction : row

  pmps_levels_t rd_d;

  // one row per supported code
  always_comb begin
    case (code_in)
      4'h5:    rd_d = row(MV_1225, MV_1200, MV_1500, MV_1500, MV_1200, MV_2775, MV_1200, MV_2500);
      4'h6:    rd_d = row(MV_1300, MV_1300, MV_1800, MV_1800, MV_1300, MV_2775, MV_1300, MV_2500);
      4'h7:    rd_d = row(MV_1300, MV_1200, MV_1500, MV_1500, MV_1300, MV_2775, MV_1300, MV_2500);
      4'h8:    rd_d = row(MV_1300, MV_1200, MV_1350, MV_1350, MV_1300, MV_2775, MV_1300, MV_2500);
      4'h9:    rd_d = row(MV_1300, MV_1200, MV_1200, MV_1200, MV_1300, MV_2775, MV_1300, MV_2500);
      4'hA:    rd_d = row(MV_1200, MV_1200, MV_1800, MV_1800, MV_1200, MV_2500, MV_1200, MV_3100);
      4'hB:    rd_d = row(MV_1200, MV_1200, MV_1200, MV_1200, MV_1200, MV_2500, MV_1200, MV_3100);
      4'hC:    rd_d = row(MV_1200, MV_1200, MV_3150, MV_1200, MV_1200, MV_2500, MV_1200, MV_3100);
      4'hD:    rd_d = row(MV_1200, MV_1200, MV_3150, MV_1800, MV_1200, MV_2500, MV_1200, MV_3100);
      4'hE:    rd_d = row(MV_1200, MV_1200, MV_3150, MV_1200, MV_1200, MV_2500, MV_1200, MV_2500);
      4'hF:    rd_d = row(MV_1200, MV_1200, MV_3150, MV_1800, MV_1200, MV_2500, MV_1200, MV_2500);
      default: rd_d = '0;
    endcase
  end

  // registered read port
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      levels_out <= '0;
    end else begin
      levels_out <= rd_d;
    end
  end

endmodule : pmps_defaults_rom

// file: rtl/pmps_sequencer.sv
// Purpose: power-up sequencer, core supplies then ten 2 ms regulator slots
// Assumes: power_ok_in is the valid-supply level; straps are static pins
// Notes:   a drop of power_ok_in aborts and later restarts from the top
`timescale 1ns/1ps
module pmps_sequencer
  import pmps_pkg::*;
#(
  // clocks per time-base tick; only a fast bench shortens it, and must keep it above 8
  parameter logic [9:0] TICK_DIV = pmps_pkg::TB_DIV
)
(
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  // supply and detector inputs
  input  wire logic                  power_ok_in,
  input  wire logic                  usb_bus_voltage_ok_in,
  input  wire logic                  main_battery_uv_in,
  // configuration straps
  input  wire logic [3:0]            power_up_strap_in,
  input  wire logic                  pass_device_strap_in,
  // core supplies
  output logic                       digital_core_supply_en_out,
  output logic                       rtc_supply_en_out,
  output logic                       analog_core_supply_en_out,
  // regulator control
  output logic [pmps_pkg::NREG-1:0]  reg_en_out,
  output logic [pmps_pkg::NBUCK-1:0] buck_pull_down_out,
  output pmps_pkg::pmps_mode_t       buck_mode_out [pmps_pkg::NBUCK],
  output logic                       internal_pass_out,
  output logic                       usb_from_boost_out,
  // default levels in millivolts
  output logic [11:0]                core_buck_mv_out,
  output logic [11:0]                vcc_buck_mv_out,
  output logic [11:0]                analog_buck_mv_out,
  output logic [11:0]                memory_buck_a_mv_out,
  output logic [11:0]                memory_buck_b_mv_out,
  output logic [11:0]                io_buck_mv_out,
  output logic [11:0]                usb_ldo_mv_out,
  output logic [11:0]                usb_aux_ldo_mv_out,
  output logic [11:0]                rtc_supply_mv_out,
  output logic [11:0]                pll_ldo_mv_out,
  output logic [11:0]                dac_ldo_mv_out,
  output logic [11:0]                general_purpose1_ldo_mv_out,
  output logic [11:0]                general_purpose2_ldo_mv_out,
  // status
  output logic                       seq_done_out,
  output logic                       battery_uv_event_out
);
  import pmps_pkg::*;

  // ==========================================================
  // time base and defaults
  logic         tick;
  pmps_levels_t levels;
  logic [3:0]   strap_q;
  logic         pass_q;

  pmps_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .tick_out   (tick)
  );

  pmps_defaults_rom u_rom (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .code_in    (strap_q),
    .levels_out (levels)
  );

  // ==========================================================
  // sequence state
  pmps_state_t       state_q;
  logic [8:0]        cnt_q;
  logic [3:0]        slot_q;
  logic [NREG-1:0]   en_q;
  logic              uv_q;

  // family decode from the latched code, never from the live pins
  wire               fam_a     = (strap_q >= CODE_A_LO) && (strap_q <= CODE_A_HI);
  wire               fam_b     = (strap_q >= CODE_B_LO);
  wire               start     = (state_q == ST_OFF) && power_ok_in;
  wire               pre_end   = (state_q == ST_PRESEQ) && tick
                                 && (cnt_q == PRESEQ_TICKS - 9'h001);
  wire               slot_end  = (state_q == ST_SLOTS) && tick
                                 && (cnt_q == SLOT_TICKS - 9'h001);
  wire               last      = (slot_q == LAST_SLOT);
  wire [3:0]         nxt_slot  = (state_q == ST_PRESEQ) ? 4'h0 : slot_q + 4'h1;
  wire [NREG-1:0]    raw_mask  = fam_a ? SLOT_A[nxt_slot] :
                                 fam_b ? SLOT_B[nxt_slot] : '0;
  // usb ldo dropped from its slot without bus voltage; boost never set
  wire [NREG-1:0]    usb_gate  = usb_bus_voltage_ok_in ? '1 : ~(NREG'(1) << EN_USB);
  wire [NREG-1:0]    slot_mask = raw_mask & usb_gate & ~(NREG'(1) << EN_BOOST);
  wire               open_slot = pre_end || (slot_end && !last);

  // state machine; loss of power wins over everything so no partial state is kept
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_OFF;
      cnt_q   <= 9'h000;
      slot_q  <= 4'h0;
      en_q    <= '0;
    end else if (!power_ok_in) begin
      state_q <= ST_OFF;
      cnt_q   <= 9'h000;
      slot_q  <= 4'h0;
      en_q    <= '0;
    end else begin
      case (state_q)
        ST_OFF: begin
          state_q <= ST_PRESEQ;
          cnt_q   <= 9'h000;
        end
        ST_PRESEQ, ST_SLOTS: begin
          if (open_slot) begin
            state_q <= ST_SLOTS;
            slot_q  <= nxt_slot;
            en_q    <= en_q | slot_mask;
            cnt_q   <= 9'h000;
          end else if (slot_end) begin
            state_q <= ST_DONE;
          end else if (tick) begin
            cnt_q   <= cnt_q + 9'h001;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // straps caught on the way out of off, before any regulator slot
  always_ff @(posedge clk_sys_in) begin
    if (start) begin
      strap_q <= power_up_strap_in;
      pass_q  <= pass_device_strap_in;
    end
  end

  // undervoltage only reported once sequencing is over
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      uv_q <= 1'b0;
    end else begin
      uv_q <= main_battery_uv_in && (state_q == ST_DONE) && power_ok_in;
    end
  end

  // ==========================================================
  // per-buck pwm hold after enable
  genvar gi;
  generate
    for (gi = 0; gi < NBUCK; gi++) begin : g_buck
      logic [6:0] hold_q;
      wire        hold = en_q[gi] && (hold_q != PWM_TICKS);
      // counts ticks since enable, saturates at the hold length
      always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
          hold_q <= 7'h00;
        end else if (!en_q[gi]) begin
          hold_q <= 7'h00;
        end else if (hold && tick) begin
          hold_q <= hold_q + 7'h01;
        end
      end
      assign buck_mode_out[gi]      = !en_q[gi] ? MODE_OFF :
                                      hold      ? MODE_PWM : MODE_APS;
      assign buck_pull_down_out[gi] = !en_q[gi];
    end
  endgenerate

  // ==========================================================
  // outputs
  wire core_on = (state_q != ST_OFF);
  assign digital_core_supply_en_out  = core_on;
  assign rtc_supply_en_out           = core_on;
  assign analog_core_supply_en_out   = core_on;
  assign reg_en_out                  = en_q;
  assign internal_pass_out           = pass_q;
  assign usb_from_boost_out          = 1'b0;
  assign seq_done_out                = (state_q == ST_DONE);
  assign battery_uv_event_out        = uv_q;
  assign core_buck_mv_out            = levels.core;
  assign vcc_buck_mv_out             = levels.vcc;
  assign analog_buck_mv_out          = levels.ana;
  assign memory_buck_a_mv_out        = levels.mem_a;
  assign memory_buck_b_mv_out        = levels.mem_b;
  assign io_buck_mv_out              = levels.io;
  assign usb_ldo_mv_out              = levels.usb;
  assign usb_aux_ldo_mv_out          = levels.aux;
  assign rtc_supply_mv_out           = levels.rtc;
  assign pll_ldo_mv_out              = levels.pll;
  assign dac_ldo_mv_out              = levels.dac;
  assign general_purpose1_ldo_mv_out = levels.gp1;
  assign general_purpose2_ldo_mv_out = levels.gp2;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  property p_preseq_quiet;
    state_q == ST_PRESEQ |-> en_q == '0 && analog_core_supply_en_out;
  endproperty
  a_preseq_quiet: assert property (p_preseq_quiet) else $error("regulator on in presequence");

  property p_slot_on_tick;
    (state_q == ST_SLOTS && $changed(slot_q)) |-> $past(tick);
  endproperty
  a_slot_on_tick: assert property (p_slot_on_tick) else $error("slot moved off tick");

  property p_pull_down;
    ##1 buck_pull_down_out == ~en_q[NBUCK-1:0];
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("pull-down wrong");

  property p_uv_masked;
    $rose(battery_uv_event_out) |-> $past(state_q) == ST_DONE;
  endproperty
  a_uv_masked: assert property (p_uv_masked) else $error("undervoltage not masked");

  property p_pwm_start;
    $rose(en_q[EN_VCC]) |-> (buck_mode_out[EN_VCC] == MODE_PWM || !en_q[EN_VCC]) [*8];
  endproperty
  a_pwm_start: assert property (p_pwm_start) else $error("buck not in pwm at start");

  property p_aps_after;
    en_q[EN_CORE] && g_buck[EN_CORE].hold_q == PWM_TICKS |-> buck_mode_out[EN_CORE] == MODE_APS;
  endproperty
  a_aps_after: assert property (p_aps_after) else $error("buck not in auto pulse skip");

  property p_strap_hold;
    (state_q != ST_OFF && $past(state_q) != ST_OFF) |-> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap latch changed");

  property p_cut;
    !power_ok_in |=> en_q == '0 && state_q == ST_OFF;
  endproperty
  a_cut: assert property (p_cut) else $error("state kept over power cut");

  property p_boost_off;
    !reg_en_out[EN_BOOST] && !usb_from_boost_out;
  endproperty
  a_boost_off: assert property (p_boost_off) else $error("boost enabled");

  property p_first_slot;
    (state_q == ST_SLOTS && slot_q == 4'h0 && (fam_a || fam_b)) |-> en_q[EN_VCC];
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("vcc buck not first");

  property p_usb_gate;
    $rose(en_q[EN_USB]) |-> $past(usb_bus_voltage_ok_in);
  endproperty
  a_usb_gate: assert property (p_usb_gate) else $error("usb ldo without bus");

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("time base too fast");

  property p_mask_grows;
    (state_q != ST_OFF && $past(state_q) != ST_OFF) |-> (en_q & $past(en_q)) == $past(en_q);
  endproperty
  a_mask_grows: assert property (p_mask_grows) else $error("regulator dropped in sequence");

  property p_core_first;
    reg_en_out != '0 |-> digital_core_supply_en_out && rtc_supply_en_out
                         && analog_core_supply_en_out;
  endproperty
  a_core_first: assert property (p_core_first) else $error("regulator without core");

  property p_reserved_quiet;
    (state_q != ST_OFF && !fam_a && !fam_b) |-> en_q == '0;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code enabled");

  c_done: cover property (state_q == ST_SLOTS ##1 state_q == ST_DONE);
  c_cut_in_pre: cover property (state_q == ST_PRESEQ ##1 state_q == ST_OFF);
  c_usb_skip: cover property (slot_end && !usb_bus_voltage_ok_in && fam_a);
  c_aps_mode: cover property (en_q[EN_VCC] ##1 buck_mode_out[EN_VCC] == MODE_APS);

endmodule : pmps_sequencer

// file: sim/pmps_partner.sv
// Purpose: strap pins and supply monitors around the sequencer
// Assumes: the bench names the wanted levels on falling edges
// Notes:   straps are static wiring, so they only move when asked
`timescale 1ns/1ps
module pmps_partner (
  // clock
  input  wire logic       clk_sys_in,
  // wanted levels
  input  wire logic       p_ok_in,
  input  wire logic       usb_in,
  input  wire logic       uv_in,
  input  wire logic       pass_in,
  input  wire logic [3:0] code_in,
  // pins toward the sequencer
  output logic            power_ok_out,
  output logic            usb_ok_out,
  output logic            uv_out,
  output logic            pass_out,
  output logic [3:0]      strap_out
);
  // ==========================================================
  // pins follow on the next rising edge, after the design has sampled,
  // so bench and pins never race on one falling edge
  always @(posedge clk_sys_in) begin
    {power_ok_out, usb_ok_out, uv_out, pass_out, strap_out} <=
      {p_ok_in, usb_in, uv_in, pass_in, code_in};
  end
endmodule : pmps_partner

// file: sim/test_pmic_power_up_sequencer.sv
// Purpose: self-checking bench of the power-up sequencer
// Assumes: 25 MHz clock, time base shortened to one tick every TK clocks
// Notes:   two full sequences, so the run is long but bounded
`timescale 1ns/1ps
module test_pmic_power_up_sequencer;
  import pmps_pkg::*;
  localparam int TK = 12;  // clocks per tick, short so the run stays brief
  // ==========================================================
  // slot contents per family, -1 where a place is empty
  localparam int ORD [2][10][2] = '{
    '{'{EN_VCC,-1}, '{EN_PLL,-1}, '{EN_GP2,-1}, '{EN_ANA,-1}, '{EN_CORE,-1},
      '{EN_MEM,EN_MREF}, '{-1,-1}, '{EN_IO,EN_GP1}, '{EN_USB,EN_AUX}, '{EN_DAC,-1}},
    '{'{EN_VCC,-1}, '{EN_ANA,-1}, '{EN_CORE,-1}, '{EN_DAC,-1}, '{EN_MEM,EN_MREF},
      '{EN_IO,-1}, '{EN_GP2,EN_AUX}, '{EN_PLL,-1}, '{EN_GP1,-1}, '{EN_USB,-1}}};
  logic              clk_sys_in, reset_in, p_ok, usb, uv, pass;
  logic [3:0]        code;
  wire logic         power_ok, usb_ok, uv_pin, pass_pin;
  wire logic [3:0]   strap;
  logic              dcore, rtc, acore, ipass, boost_feed, seq_done_out, uv_ev;
  logic [NREG-1:0]   reg_en_out;
  logic [NBUCK-1:0]  pd;
  pmps_mode_t        mode [NBUCK];
  logic [11:0]       core_mv, vcc_mv, ana_mv, mema_mv, memb_mv, io_mv, usb_mv, aux_mv;
  logic [11:0]       rtc_mv, pll_mv, dac_mv, gp1_mv, gp2_mv;
  int                failures, total_checks;

  // ==========================================================
  // clock and parts
  always #20 clk_sys_in = ~clk_sys_in;
  pmps_partner u_pins (.clk_sys_in(clk_sys_in), .p_ok_in(p_ok), .usb_in(usb), .uv_in(uv),
    .pass_in(pass), .code_in(code), .power_ok_out(power_ok), .usb_ok_out(usb_ok),
    .uv_out(uv_pin), .pass_out(pass_pin), .strap_out(strap));
  pmps_sequencer #(.TICK_DIV(10'(TK))) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .power_ok_in(power_ok), .usb_bus_voltage_ok_in(usb_ok), .main_battery_uv_in(uv_pin),
    .power_up_strap_in(strap), .pass_device_strap_in(pass_pin),
    .digital_core_supply_en_out(dcore), .rtc_supply_en_out(rtc),
    .analog_core_supply_en_out(acore), .reg_en_out(reg_en_out), .buck_pull_down_out(pd),
    .buck_mode_out(mode), .internal_pass_out(ipass), .usb_from_boost_out(boost_feed),
    .core_buck_mv_out(core_mv), .vcc_buck_mv_out(vcc_mv), .analog_buck_mv_out(ana_mv),
    .memory_buck_a_mv_out(mema_mv), .memory_buck_b_mv_out(memb_mv), .io_buck_mv_out(io_mv),
    .usb_ldo_mv_out(usb_mv), .usb_aux_ldo_mv_out(aux_mv), .rtc_supply_mv_out(rtc_mv),
    .pll_ldo_mv_out(pll_mv), .dac_ldo_mv_out(dac_mv), .general_purpose1_ldo_mv_out(gp1_mv),
    .general_purpose2_ldo_mv_out(gp2_mv), .seq_done_out(seq_done_out),
    .battery_uv_event_out(uv_ev));

  // ==========================================================
  // shared checking and closing
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  function automatic logic [12:0] slot_mask(input int f, input int k, input logic u);
    logic [12:0] m;
    m = '0;
    for (int j = 0; j < 2; j++) begin
      if (ORD[f][k][j] >= 0) m[ORD[f][k][j]] = 1'b1;
    end
    if (u !== 1'b1) m[EN_USB] = 1'b0;  // no bus voltage, no usb ldo
    return m;
  endfunction : slot_mask

  // ==========================================================
  // supply steps
  task automatic power_on(input logic [3:0] c, input logic pd_s, input logic u);
    int n;
    code = c;
    pass = pd_s;
    usb = u;
    p_ok = 1'b1;
    n = 0;
    while (dcore !== 1'b1 && n < 8) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(rtc === 1'b1 && acore === 1'b1 && reg_en_out === '0 && n < 8, "core supplies");
    repeat (3) @(negedge clk_sys_in);
    chk(ipass === pd_s && boost_feed === 1'b0, "pass device or usb feed");
  endtask : power_on

  task automatic cut_power;
    p_ok = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk(reg_en_out === '0 && dcore === 1'b0 && seq_done_out === 1'b0, "cut");
    chk(pd === 5'h1F && mode[EN_VCC] === MODE_OFF, "cut leaves bucks");
  endtask : cut_power

  // whole sequence, each slot edge after the first checked one clock early and on time;
  // pre is the clocks already gone since the start edge when this begins
  task automatic run_seq(input int f, input logic u, input int pre);
    logic [12:0] acc;
    int n;
    acc = '0;
    n = 0;
    while (reg_en_out === '0 && n < 264 * TK) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(n + pre > 261 * TK && n + pre <= 262 * TK, "presequence length");
    for (int k = 0; k <= 10; k++) begin
      if (k > 0) begin
        repeat (66 * TK - 1) @(negedge clk_sys_in);
        chk(reg_en_out === acc && seq_done_out === 1'b0, "slot early");
        @(negedge clk_sys_in);
      end
      if (k < 10) acc = acc | slot_mask(f, k, u);
      chk(reg_en_out === acc, "slot mask");
      chk(pd === ~acc[4:0], "pull-downs");
      if (k < 10) chk(uv_ev === 1'b0, "uv not masked");
      if (k == 1) chk(mode[EN_VCC] === MODE_PWM && mode[EN_IO] === MODE_OFF, "pwm");
      if (k == 2) chk(mode[EN_VCC] === MODE_APS, "mode after hold");
    end
    chk(seq_done_out === 1'b1, "done");
    repeat (2) @(negedge clk_sys_in);
    chk(uv_ev === 1'b1, "uv after done");
  endtask : run_seq

  // ==========================================================
  // scenarios
  task automatic test_reserved_cut;
    power_on(4'h2, 1'b1, 1'b1);
    chk(core_mv === 12'h0000 && vcc_mv === 12'h0000, "reserved levels");
    chk(memb_mv === 12'h000 && gp1_mv === 12'h000, "reserved rails");
    repeat (100 * TK) @(negedge clk_sys_in);
    chk(reg_en_out === '0, "reserved enables");
    cut_power();
  endtask : test_reserved_cut

  task automatic test_family_a;
    power_on(4'h5, 1'b0, 1'b0);
    chk(vcc_mv === MV_1225 && dac_mv === MV_2775 && gp2_mv === MV_2500, "a levels");
    chk(core_mv === MV_1100 && mema_mv === MV_1500, "a bucks");
    chk(ana_mv === MV_1200 && memb_mv === MV_1500 && io_mv === MV_1800, "a rails");
    chk(usb_mv === MV_3300 && aux_mv === MV_2500 && pll_mv === MV_1800, "a ldos");
    chk(rtc_mv === MV_1200 && gp1_mv === MV_1200, "a rtc and gp1");
    run_seq(0, 1'b0, 3);
    cut_power();
  endtask : test_family_a

  task automatic test_family_b;
    power_on(4'hC, 1'b1, 1'b1);
    code = 4'h5;
    pass = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    chk(vcc_mv === MV_1200 && mema_mv === MV_3150 && gp2_mv === MV_3100, "b levels");
    chk(ipass === 1'b1, "pass strap held");
    chk(ana_mv === MV_1200 && memb_mv === MV_1200 && dac_mv === MV_2500, "b rails");
    chk(rtc_mv === MV_1200 && gp1_mv === MV_1200 && core_mv === MV_1100, "b ldos");
    run_seq(1, 1'b1, 7);
  endtask : test_family_b

  // ==========================================================
  // main sequence and watchdog
  initial begin
    clk_sys_in = 1'b0;
    reset_in = 1'b1;
    {p_ok, usb, uv, pass, code} = '0;
    failures = 0;
    total_checks = 0;
    repeat (4) @(negedge clk_sys_in);
    reset_in = 1'b0;
    uv = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk(dcore === 1'b0 && reg_en_out === '0 && pd === 5'h1F, "idle after reset");
    test_reserved_cut();
    test_family_a();
    test_family_b();
    finish_test();
  end

  initial begin
    #2_400_000;  // about 2.5 times the expected run
    failures++;
    finish_test();
  end
endmodule : test_pmic_power_up_sequencer
